// ### hw/fsp_defs.svh
// Opcodes, field positions, reset values and sizes of the sector protection.
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH

`define FSP_OP_WREN      8'h06
`define FSP_OP_WRDI      8'h04
`define FSP_OP_PROT      8'h36
`define FSP_OP_UNPROT    8'h39
`define FSP_OP_WRSR1     8'h01

`define FSP_NUM_SECT     64
`define FSP_SECT_W       6
`define FSP_SECT_HI      5
`define FSP_PROT_RST     64'hFFFF_FFFF_FFFF_FFFF
`define FSP_PROT_BIT_RST 1'b1
`define FSP_WEL_RST      1'b0
`define FSP_LOCK_RST     1'b0

`define FSP_SR_LOCK_BIT  7
`define FSP_SR_GLB_HI    5
`define FSP_SR_GLB_LO    2
`define FSP_GLB_ALL1     4'hF
`define FSP_GLB_ALL0     4'h0

`define FSP_BITS_OP      6'h08
`define FSP_BITS_B1      6'h10
`define FSP_BITS_ADDR    6'h20
`define FSP_CNT_TOP      6'h3F
`define FSP_CNT_WRAP     6'h38
`define FSP_LAST_OP_BIT  6'h07
`define FSP_LAST_B1_BIT  6'h0F

`endif

// ### hw/fsp_pkg.sv
// Types shared by the sector protection logic.
package fsp_pkg;

  // Snapshot of one serial frame, built in the link clock domain.
  typedef struct packed {
    logic       seq;
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic       got_op;
    logic       got_b1;
    logic       got_addr;
    logic [2:0] bit_mod8;
  } fsp_frame_t;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_EXEC
  } fsp_state_t;

endpackage

// ### hw/fsp_sector_prot.sv
// Sector protection flags, write enable latch and lock bit of a serial flash.
`timescale 1ns/10ps
`include "fsp_defs.svh"


module fsp_sector_prot
  import fsp_pkg::*;
(
  // Core clock and reset
  input  wire logic                    core_clk_i,
  input  wire logic                    sys_rst_i,
  // Serial link
  input  wire logic                    spi_sck_i,
  input  wire logic                    spi_cs_n_i,
  input  wire logic                    spi_mosi_i,
  // Device status
  input  wire logic                    wp_n_i,
  input  wire logic                    op_suspended_i,
  input  wire logic [`FSP_SECT_W-1:0]  check_sector_i,
  // Protection state
  output logic      [`FSP_NUM_SECT-1:0] sector_prot_o,
  output logic                         write_enable_latch_o,
  output logic                         protection_regs_lock_o,
  output logic                         sector_writable_o
);

  // ****************************************************************
  // Link clock domain
  // ****************************************************************
  logic [5:0]  bit_cnt;
  logic [7:0]  shift;
  fsp_frame_t  link_frame;
  logic [5:0]  next_bit_cnt;
  logic [7:0]  next_shift;
  logic [7:0]  shifted_byte;
  fsp_frame_t  next_frame;

  // Past the address the count wraps inside the top octet, so the bit
  // alignment and the address-complete flag both stay exact.
  assign next_bit_cnt = (bit_cnt == `FSP_CNT_TOP) ? `FSP_CNT_WRAP
                                                  : bit_cnt + 6'h01;
  assign shifted_byte = {shift[6:0], spi_mosi_i};
  assign next_shift   = shifted_byte;

  assign next_frame.seq      = link_frame.seq ^ (bit_cnt == 6'h00);
  assign next_frame.opcode   = (bit_cnt == `FSP_LAST_OP_BIT) ? shifted_byte
                                                             : link_frame.opcode;
  assign next_frame.byte1    = (bit_cnt == `FSP_LAST_B1_BIT) ? shifted_byte
                                                             : link_frame.byte1;
  assign next_frame.got_op   = next_bit_cnt >= `FSP_BITS_OP;
  assign next_frame.got_b1   = next_bit_cnt >= `FSP_BITS_B1;
  assign next_frame.got_addr = next_bit_cnt >= `FSP_BITS_ADDR;
  assign next_frame.bit_mod8 = next_bit_cnt[2:0];

  // The frame's own select ends the bit count; no sclk edge follows it.
  always_ff @(posedge spi_sck_i or posedge spi_cs_n_i)
  begin
    if (spi_cs_n_i)
    begin
      bit_cnt <= 6'h00;
      shift   <= 8'h00;
    end
    else
    begin
      bit_cnt <= next_bit_cnt;
      shift   <= next_shift;
    end
  end

  // The snapshot outlives the frame so the core can read it afterwards.
  always_ff @(posedge spi_sck_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      link_frame <= '0;
    else
      link_frame <= next_frame;
  end

  // ****************************************************************
  // Core domain: synchronisers and frame capture
  // ****************************************************************
  logic       cs_meta;
  logic       cs_sync;
  logic       cs_prev;
  logic       wp_meta;
  logic       wp_sync;
  logic       last_seq;
  fsp_frame_t frame_q;
  fsp_state_t state;
  fsp_state_t next_state;
  logic       cs_rise;

  assign cs_rise    = cs_sync & ~cs_prev;
  assign next_state = cs_rise ? ST_EXEC : ST_IDLE;

  // The snapshot is only taken after select has been high for two core
  // cycles, when the stopped link clock has left it stable.
  always_ff @(posedge core_clk_i)
  begin
    cs_meta <= spi_cs_n_i;
    cs_sync <= cs_meta;
    wp_meta <= wp_n_i;
    wp_sync <= wp_meta;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      state    <= ST_IDLE;
      frame_q  <= '0;
      last_seq <= 1'b0;
      // Starting at the idle level of select keeps reset from faking a frame end.
      cs_prev  <= 1'b1;
    end
    else
    begin
      cs_prev <= cs_sync;
      state <= next_state;
      if (cs_rise)
        frame_q <= link_frame;
      if (state == ST_EXEC)
        last_seq <= frame_q.seq;
    end
  end

  // ****************************************************************
  // Command decode
  // ****************************************************************
  logic [`FSP_NUM_SECT-1:0] prot;
  logic                     write_enable_latch;
  logic                     lock;
  logic                     exec_now;
  logic                     fresh;
  logic                     aligned;
  logic                     is_wren;
  logic                     is_wrdi;
  logic                     is_prot;
  logic                     is_unprot;
  logic                     is_wrsr;
  logic                     addr_ok;
  logic [`FSP_SECT_W-1:0]   sel;
  logic [3:0]               glb_bits;
  logic                     hard_lock;
  logic                     do_wren;
  logic                     do_wrdi;
  logic                     do_prot;
  logic                     do_unprot;
  logic                     wsr_ok;
  logic                     glb_req;
  logic                     glb_abort;
  logic                     do_glb_prot;
  logic                     do_glb_unprot;
  logic                     lock_write;
  logic                     new_lock;
  logic                     wel_clear;
  logic                     next_wel;
  logic                     next_lock;
  logic                     writable_now;

  // A frame without a single sclk edge leaves the sequence bit alone.
  assign exec_now  = state == ST_EXEC;
  assign fresh     = exec_now & (frame_q.seq != last_seq);
  assign aligned   = frame_q.bit_mod8 == 3'h0;
  assign is_wren   = fresh & frame_q.got_op
                   & (frame_q.opcode == `FSP_OP_WREN);
  assign is_wrdi   = fresh & frame_q.got_op
                   & (frame_q.opcode == `FSP_OP_WRDI);
  assign is_prot   = fresh & frame_q.got_op
                   & (frame_q.opcode == `FSP_OP_PROT);
  assign is_unprot = fresh & frame_q.got_op
                   & (frame_q.opcode == `FSP_OP_UNPROT);
  assign is_wrsr   = fresh & frame_q.got_op
                   & (frame_q.opcode == `FSP_OP_WRSR1);
  assign addr_ok   = frame_q.got_addr & aligned;
  assign sel       = frame_q.byte1[`FSP_SECT_HI:0];
  assign glb_bits  = frame_q.byte1[`FSP_SR_GLB_HI:`FSP_SR_GLB_LO];
  assign new_lock  = frame_q.byte1[`FSP_SR_LOCK_BIT];
  assign hard_lock = ~wp_sync & lock;

  assign do_wren   = is_wren & aligned;
  assign do_wrdi   = is_wrdi & aligned;
  assign do_prot   = is_prot & addr_ok & write_enable_latch & ~lock;
  assign do_unprot = is_unprot & addr_ok & write_enable_latch & ~lock;

  assign wsr_ok        = is_wrsr & frame_q.got_b1 & aligned & write_enable_latch
                       & ~hard_lock;
  assign glb_req       = wsr_ok & ~lock;
  assign glb_abort     = glb_req & (glb_bits == `FSP_GLB_ALL1)
                       & op_suspended_i;
  assign do_glb_prot   = glb_req & (glb_bits == `FSP_GLB_ALL1)
                       & ~op_suspended_i;
  assign do_glb_unprot = glb_req & (glb_bits == `FSP_GLB_ALL0);
  assign lock_write    = wsr_ok & ~glb_abort;

  // Any frame of a latch-guarded command ends with the latch cleared.
  assign wel_clear = is_prot | is_unprot | is_wrsr | do_wrdi;
  assign next_wel  = do_wren ? 1'b1 : (wel_clear ? 1'b0 : write_enable_latch);
  assign next_lock = lock_write ? new_lock : lock;
  assign writable_now = ~prot[check_sector_i];

  // ****************************************************************
  // Protection state
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < `FSP_NUM_SECT; g = g + 1)
    begin : g_sect
      logic hit;
      logic next_flag;
      assign hit = sel == `FSP_SECT_W'(g);
      // Per-sector commands act on top of whatever a global write left.
      assign next_flag = do_glb_prot   ? 1'b1 :
                         do_glb_unprot ? 1'b0 :
                         (do_prot & hit)   ? 1'b1 :
                         (do_unprot & hit) ? 1'b0 :
                         prot[g];
      always_ff @(posedge core_clk_i)
      begin
        if (sys_rst_i)
          prot[g] <= `FSP_PROT_BIT_RST;
        else
          prot[g] <= next_flag;
      end
    end
  endgenerate

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      write_enable_latch               <= `FSP_WEL_RST;
      lock              <= `FSP_LOCK_RST;
      sector_writable_o <= 1'b0;
    end
    else
    begin
      write_enable_latch               <= next_wel;
      lock              <= next_lock;
      sector_writable_o <= writable_now;
    end
  end

  assign sector_prot_o          = prot;
  assign write_enable_latch_o   = write_enable_latch;
  assign protection_regs_lock_o = lock;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_reset_all_prot:
    assert property (disable iff (1'b0) sys_rst_i |=> &sector_prot_o)
    else $error("Sectors not all protected after reset.");

  a_prot_sets_flag:
    assert property (do_prot |=> prot[$past(sel)] && !write_enable_latch)
    else $error("Protect did not set the flag or clear the latch.");

  a_unprot_clr_flag:
    assert property (do_unprot |=> !prot[$past(sel)] && !write_enable_latch)
    else $error("Unprotect did not clear the flag or the latch.");

  a_no_latch_hold:
    assert property ((is_prot || is_unprot) && !write_enable_latch |=> prot == $past(prot))
    else $error("Flag changed without the write enable latch.");

  a_short_abort:
    assert property ((is_prot || is_unprot) && !addr_ok
                     |=> prot == $past(prot) && !write_enable_latch)
    else $error("Aborted frame changed a flag or kept the latch.");

  a_lock_ignores:
    assert property ((is_prot || is_unprot) && lock
                     |=> prot == $past(prot) && !write_enable_latch)
    else $error("Locked registers changed a flag.");

  a_glb_prot_all:
    assert property (do_glb_prot |=> &sector_prot_o && !write_enable_latch)
    else $error("Global protect left a sector open.");

  a_glb_unprot_all:
    assert property (do_glb_unprot |=> sector_prot_o == '0)
    else $error("Global unprotect left a sector protected.");

  a_glb_abort_hold:
    assert property (glb_abort |=> prot == $past(prot) && !write_enable_latch)
    else $error("Global protect ran during a suspend.");

  a_hard_lock_hold:
    assert property (exec_now && hard_lock
                     |=> lock && prot == $past(prot))
    else $error("Hard-locked state changed.");

  a_frame_to_update:
    assert property (cs_rise |=> exec_now ##1 !exec_now)
    else $error("Frame end not executed once.");

  c_prot_done:     cover property (do_prot);
  c_unprot_done:   cover property (do_unprot);
  c_glb_prot:      cover property (do_glb_prot ##[1:600] do_unprot);
  c_glb_aborted:   cover property (glb_abort);

endmodule

// ### verification/fsp_spi_host.sv
// Behavioural serial host that frames commands towards the flash block.
`timescale 1ns/10ps

module fsp_spi_host
(
  // Serial link
  output logic sck_o,
  output logic cs_n_o,
  output logic mosi_o
);
  // *****************************************
  // Link drive
  // *****************************************
  // The link clock stands still low between frames, mode 0 style.
  initial
  begin
    sck_o  = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // Sends the n most significant bits of d, MSB first, 30 ns per bit.
  // Opcode, then three address bytes or the status byte.
  task automatic frame(input logic [39:0] d, input int n);
    cs_n_o = 1'b0;
    #7;
    for (int i = 0; i < n; i++)
    begin
      mosi_o = d[39-i];
      #15 sck_o = 1'b1;
      #15 sck_o = 1'b0;
    end
    #7 cs_n_o = 1'b1;
    // A released line must not look like held data.
    mosi_o = ~mosi_o;
  endtask
endmodule

// ### verification/test_flash_sector_protection.sv
// Self-checking bench for the sector protection block.
`timescale 1ns/10ps
`include "fsp_defs.svh"

module test_flash_sector_protection import fsp_pkg::*;;
  typedef struct packed {
    logic [63:0] prot;
    logic        write_enable_latch;
    logic        lock;
  } fsp_note_t;

  logic        core_clk = 1'b0;
  logic        sys_rst  = 1'b1;
  logic        wp_n     = 1'b1;
  logic        op_susp  = 1'b0;
  logic [5:0]  chk_sec  = 6'h00;
  logic [63:0] prot;
  logic        write_enable_latch;
  logic        lock;
  logic        wr;
  wire         sck;
  wire         cs_n;
  wire         mosi;
  logic [63:0] exp_prot = 64'hFFFF_FFFF_FFFF_FFFF;
  logic        exp_wel  = 1'b0;
  logic        exp_lock = 1'b0;
  fsp_note_t   q[$];
  fsp_note_t   got;
  int          n_errors     = 0;
  int          total_checks = 0;
  int          cyc          = 0;
  int          seed         = 62282;
  event        ev;

  always #2.5 core_clk = ~core_clk;

  fsp_spi_host u_fsp_spi_host (.sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi));

  fsp_sector_prot u_fsp_sector_prot (
    .core_clk_i            (core_clk),
    .sys_rst_i             (sys_rst),
    .spi_sck_i             (sck),
    .spi_cs_n_i            (cs_n),
    .spi_mosi_i            (mosi),
    .wp_n_i                (wp_n),
    .op_suspended_i        (op_susp),
    .check_sector_i        (chk_sec),
    .sector_prot_o         (prot),
    .write_enable_latch_o  (write_enable_latch),
    .protection_regs_lock_o(lock),
    .sector_writable_o     (wr)
  );

  // *****************************************
  // Helpers
  // *****************************************
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic check(input string nm, input logic [63:0] e,
                       input logic [63:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Twelve cycles cover the sync, the snapshot and the registered query.
  task automatic note();
    chk_sec = 6'($random(seed));
    q.push_back('{exp_prot, exp_wel, exp_lock});
    step(12);
    ->ev;
  endtask

  task automatic wren();
    u_fsp_spi_host.frame({`FSP_OP_WREN, 32'h0}, 8);
    exp_wel = 1'b1;
    note();
  endtask

  task automatic wrdi();
    u_fsp_spi_host.frame({`FSP_OP_WRDI, 32'h0}, 8);
    exp_wel = 1'b0;
    note();
  endtask

  // Upper address bits 23:22 and the low bytes are noise the block ignores.
  task automatic sect(input logic [7:0] op, input logic [5:0] s, input int n);
    logic [17:0] junk;
    junk = 18'($random(seed));
    u_fsp_spi_host.frame({op, junk[17:16], s, junk[15:0], 8'h5A}, n);
    if (n >= 32 && n % 8 == 0 && exp_wel && !exp_lock)
      exp_prot[s] = (op == `FSP_OP_PROT);
    exp_wel = 1'b0;
    note();
  endtask

  task automatic wsr(input logic [7:0] d);
    u_fsp_spi_host.frame({`FSP_OP_WRSR1, d, 24'h0}, 16);
    if (exp_wel && (wp_n || !exp_lock) &&
        !(d[5:2] == `FSP_GLB_ALL1 && op_susp && !exp_lock))
    begin
      if (!exp_lock && d[5:2] == `FSP_GLB_ALL1)
        exp_prot = '1;
      if (!exp_lock && d[5:2] == `FSP_GLB_ALL0)
        exp_prot = '0;
      exp_lock = d[7];
    end
    exp_wel = 1'b0;
    note();
  endtask

  // *****************************************
  // Result watcher
  // *****************************************
  initial
  forever
  begin
    @(ev);
    got = q.pop_front();
    check("prot", got.prot, prot);
    check("wel", {63'h0, got.write_enable_latch}, {63'h0, write_enable_latch});
    check("lock", {63'h0, got.lock}, {63'h0, lock});
    check("writable", {63'h0, ~got.prot[chk_sec]}, {63'h0, wr});
  end

  // A hung link would otherwise never reach the report.
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_errors++;
      summarize();
    end
  end

  // *****************************************
  // Main sequence
  // *****************************************
  initial
  begin
    step(2);
    sys_rst = 1'b0;
    note();
    sect(`FSP_OP_UNPROT, 6'h05, 32);
    wren();
    wrdi();
    sect(`FSP_OP_UNPROT, 6'h05, 32);
    wren();
    sect(`FSP_OP_UNPROT, 6'h05, 32);
    wren();
    sect(`FSP_OP_PROT, 6'h05, 40);
    wren();
    sect(`FSP_OP_UNPROT, 6'h09, 32);
    wren();
    sect(`FSP_OP_UNPROT, 6'h09, 24);
    wren();
    sect(`FSP_OP_PROT, 6'h09, 31);
    wren();
    wsr(8'h00);
    wren();
    sect(`FSP_OP_PROT, 6'h03, 32);
    op_susp = 1'b1; // Global protect is aborted while an operation is suspended.
    wren();
    wsr(8'h3C);
    op_susp = 1'b0;
    wren();
    wsr(8'h3C);
    wren();
    sect(`FSP_OP_UNPROT, 6'h3F, 32);
    wren();
    wsr(8'h84);
    wren();
    sect(`FSP_OP_PROT, 6'h3F, 32);
    wren();
    sect(`FSP_OP_UNPROT, 6'h00, 32);
    wp_n = 1'b0;
    wren();
    wsr(8'h00);
    wp_n = 1'b1;
    wren();
    wsr(8'h04);
    for (int i = 0; i < 8; i++)
    begin
      wren();
      sect(($random(seed) & 1) ? `FSP_OP_PROT : `FSP_OP_UNPROT,
           6'($random(seed)), 32);
    end
    summarize();
  end
endmodule
